// *** lcd_ctrl_pkg.sv ***
package lcd_ctrl_pkg;

    // Register map
    localparam logic [31:0] WAVE_PWR_EN_OFFS = 32'h0000_0000;
    localparam logic [31:0] PUMP_DUTY_OFFS   = 32'h0000_0004;
    localparam logic [23:0] DISP_MEM_PAGE    = 24'h00_0001;
    localparam int          DISP_MEM_BYTES   = 36;

    // lcd_waveform_power_enable fields
    localparam int WAVE_SEL_BIT    = 7;
    localparam int BIAS_SRC_HI     = 5;
    localparam int BIAS_SRC_LO     = 4;
    localparam int DISP_EN_BIT     = 0;
    localparam logic [7:0] WAVE_PWR_EN_MASK = 8'hB1;
    localparam logic [7:0] WAVE_PWR_EN_RST  = 8'h00;

    // lcd_pump_duty_config fields
    localparam int PUMP_DIV_HI     = 7;
    localparam int PUMP_DIV_LO     = 5;
    localparam int DUTY_HI         = 2;
    localparam int DUTY_LO         = 1;
    localparam logic [7:0] PUMP_DUTY_MASK = 8'hE6;
    localparam logic [7:0] PUMP_DUTY_RST  = 8'h00;

    // Bias source codes
    localparam logic [1:0] BIAS_EXT_PIN  = 2'h0;
    localparam logic [1:0] BIAS_INT_REF  = 2'h1;
    localparam logic [1:0] BIAS_INT_3V   = 2'h2;
    localparam logic [1:0] BIAS_INT_VDD  = 2'h3;

    // Duty codes
    localparam logic [1:0] DUTY_4COM     = 2'h0;
    localparam logic [1:0] DUTY_6COM     = 2'h1;
    localparam logic [1:0] DUTY_8COM     = 2'h2;
    localparam logic [1:0] DUTY_NONE     = 2'h3;

    localparam int NUM_COM = 8;
    localparam int NUM_SEG = 36;

    // Drive levels of the 1/3 bias ladder
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_VC  = 2'h1;
    localparam logic [1:0] LVL_VB  = 2'h2;
    localparam logic [1:0] LVL_VA  = 2'h3;

    // Last count of the sub clock divider; sub clock / 8 gives the waveform clock
    localparam logic [2:0] LCD_CLK_DIV_LAST = 3'h7;
    localparam logic [6:0] PUMP_CNT_RST     = 7'h00;

endpackage : lcd_ctrl_pkg

// *** lcd_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_com_lvl,
    input  wire logic [7:0]  i_com_oe,
    input  wire logic [71:0] i_seg_lvl,
    input  wire logic [35:0] i_seg_oe,
    output logic             o_float,
    output logic             o_blank,
    output logic signed [3:0] o_pix_diff
);
    // Passive glass: it sees the levels the driver puts on the pins, enabled or not
    logic unused_clk;
    assign unused_clk = i_clk;
    assign o_float = (i_com_oe == 8'h00) && (i_seg_oe == 36'h0);
    assign o_blank = (i_com_lvl == 16'h0) && (i_seg_lvl == 72'h0)
                     && (&i_seg_oe);
    // Pixel of common 0 and segment 0, used for the DC balance sum
    assign o_pix_diff = $signed({2'h0, i_com_lvl[1:0]})
                        - $signed({2'h0, i_seg_lvl[1:0]});
endmodule : lcd_panel_model
`default_nettype wire

// *** segment_lcd_driver_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module segment_lcd_driver_control (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [31:0] i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic             o_wb_ack,
    output logic      [31:0] o_wb_dat,
    input  wire logic        i_sub_clk,
    input  wire logic        i_sleep,
    input  wire logic        i_idle,
    input  wire logic        i_mcu_rst,
    input  wire logic        i_wdt_rst,
    input  wire logic        i_ext_top_bias_used,
    output logic      [15:0] o_com_lvl,
    output logic      [7:0]  o_com_oe,
    output logic      [7:0]  o_com_release,
    output logic      [71:0] o_seg_lvl,
    output logic      [35:0] o_seg_oe,
    output logic             o_pump_en,
    output logic             o_pump_clk,
    output logic      [3:0]  o_bias_src_onehot
);

    logic [7:0]  ctl0_q;
    logic [7:0]  ctl2_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [7:0]  disp_mem [lcd_ctrl_pkg::DISP_MEM_BYTES];
    logic        sub_s1_q, sub_s2_q, sub_s3_q, sub_lvl_q;
    logic [2:0]  lcd_div_q;
    logic [6:0]  pump_cnt_q;
    logic [2:0]  slot_q;
    logic        half_q;
    logic        frame_pol_q;
    logic [15:0] com_lvl_q;
    logic [7:0]  com_oe_q;
    logic [7:0]  com_rel_q;
    logic [71:0] seg_lvl_q;
    logic [35:0] seg_oe_q;
    logic        pump_en_q;
    logic        pump_clk_q;
    logic [3:0]  bias_oh_q;

    // Bus decode
    wire wb_req     = i_wb_cyc & i_wb_stb;
    wire wb_wr      = wb_req & ack_q & i_wb_we & i_wb_sel[0];
    wire hit_ctl0   = (i_wb_adr == lcd_ctrl_pkg::WAVE_PWR_EN_OFFS);
    wire hit_ctl2   = (i_wb_adr == lcd_ctrl_pkg::PUMP_DUTY_OFFS);
    wire [5:0] mem_idx = i_wb_adr[7:2];
    wire hit_mem    = (i_wb_adr[31:8] == lcd_ctrl_pkg::DISP_MEM_PAGE)
                    & (i_wb_adr[1:0] == 2'h0)
                    & (mem_idx < 6'(lcd_ctrl_pkg::DISP_MEM_BYTES));

    // Control fields
    wire       wave_type_b = ctl0_q[lcd_ctrl_pkg::WAVE_SEL_BIT];
    wire [1:0] bias_src    = ctl0_q[lcd_ctrl_pkg::BIAS_SRC_HI:
                                    lcd_ctrl_pkg::BIAS_SRC_LO];
    wire       disp_en     = ctl0_q[lcd_ctrl_pkg::DISP_EN_BIT];
    wire [2:0] pump_div    = ctl2_q[lcd_ctrl_pkg::PUMP_DIV_HI:
                                    lcd_ctrl_pkg::PUMP_DIV_LO];
    wire [1:0] duty        = ctl2_q[lcd_ctrl_pkg::DUTY_HI:
                                    lcd_ctrl_pkg::DUTY_LO];

    wire duty_bad = (duty == lcd_ctrl_pkg::DUTY_NONE);
    // Enable is only honoured outside sleep and with a duty code other than DUTY_NONE
    wire disp_rst = ~disp_en | i_sleep | duty_bad;
    // Watchdog resets out of low power modes do not float the glass
    wire wdt_counts = i_wdt_rst & ~(i_idle | i_sleep);
    wire float_req  = i_mcu_rst | wdt_counts;

    wire [2:0] slot_last = (duty == lcd_ctrl_pkg::DUTY_4COM) ? 3'h3 :
                           (duty == lcd_ctrl_pkg::DUTY_6COM) ? 3'h5 :
                                                               3'h7;
    wire [7:0] com_mask  = (duty == lcd_ctrl_pkg::DUTY_4COM) ? 8'h0F :
                           (duty == lcd_ctrl_pkg::DUTY_6COM) ? 8'h3F :
                                                               8'hFF;

    // Read data, unused bits forced to zero
    wire [7:0] mem_rd  = hit_mem ? (disp_mem[mem_idx] & com_mask)
                                 : 8'h00;
    wire [7:0] rd_byte = hit_ctl0 ? (ctl0_q & lcd_ctrl_pkg::WAVE_PWR_EN_MASK) :
                         hit_ctl2 ? (ctl2_q & lcd_ctrl_pkg::PUMP_DUTY_MASK) :
                                    mem_rd;

    // Ack one cycle after the request, write at the ack edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= wb_req & ~ack_q;
            if (wb_req & ~ack_q) begin
                rdat_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctl0_q <= lcd_ctrl_pkg::WAVE_PWR_EN_RST;
            ctl2_q <= lcd_ctrl_pkg::PUMP_DUTY_RST;
        end else if (wb_wr & hit_ctl0) begin
            ctl0_q <= i_wb_dat[7:0] & lcd_ctrl_pkg::WAVE_PWR_EN_MASK;
        end else if (wb_wr & hit_ctl2) begin
            ctl2_q <= i_wb_dat[7:0] & lcd_ctrl_pkg::PUMP_DUTY_MASK;
        end
    end

    // Display memory has no reset; software must initialise it
    always_ff @(posedge i_clk) begin
        if (wb_wr & hit_mem) begin
            disp_mem[mem_idx] <= i_wb_dat[7:0];
        end
    end

    // Sub clock pin: 3 stages, a change counts once stages 2 and 3 agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sub_s1_q  <= 1'b0;
            sub_s2_q  <= 1'b0;
            sub_s3_q  <= 1'b0;
            sub_lvl_q <= 1'b0;
        end else begin
            sub_s1_q <= i_sub_clk;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
            if (sub_s2_q == sub_s3_q) begin
                sub_lvl_q <= sub_s3_q;
            end
        end
    end

    wire sub_rise = (sub_s2_q == sub_s3_q) & sub_s3_q & ~sub_lvl_q;
    wire lcd_tick = sub_rise & (lcd_div_q == lcd_ctrl_pkg::LCD_CLK_DIV_LAST);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lcd_div_q  <= 3'h0;
            pump_cnt_q <= lcd_ctrl_pkg::PUMP_CNT_RST;
        end else if (sub_rise) begin
            lcd_div_q  <= lcd_div_q + 3'h1;
            pump_cnt_q <= pump_cnt_q + 7'h01;
        end
    end

    // Pump clock tap: code 0 takes bit 6 (/128), codes 6 and 7 take bit 0
    wire [2:0] pump_tap = (pump_div >= 3'h6) ? 3'h0 : (3'h6 - pump_div);
    wire       pump_run = (bias_src == lcd_ctrl_pkg::BIAS_EXT_PIN)
                        & ~i_ext_top_bias_used;

    // Frame sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst | disp_rst) begin
            slot_q      <= 3'h0;
            half_q      <= 1'b0;
            frame_pol_q <= 1'b0;
        end else if (slot_q > slot_last) begin
            // Duty shrank while running: restart the frame at once
            slot_q <= 3'h0;
        end else if (lcd_tick) begin
            if (!wave_type_b) begin
                half_q <= ~half_q;
                if (half_q) begin
                    slot_q <= (slot_q == slot_last) ? 3'h0 : slot_q + 3'h1;
                end
            end else begin
                // Whole slot per tick, so type B frames run at twice the type A rate
                slot_q <= (slot_q == slot_last) ? 3'h0 : slot_q + 3'h1;
                if (slot_q == slot_last) begin
                    frame_pol_q <= ~frame_pol_q;
                end
            end
        end
    end

    wire pol = wave_type_b ? frame_pol_q : half_q;

    // Per-pin level selection on the 1/3 bias ladder
    logic [15:0] com_lvl_d;
    logic [71:0] seg_lvl_d;

    genvar gc;
    generate
        for (gc = 0; gc < lcd_ctrl_pkg::NUM_COM; gc++) begin : g_com
            wire sel = (slot_q == 3'(gc));
            assign com_lvl_d[2*gc +: 2] =
                sel ? (pol ? lcd_ctrl_pkg::LVL_VA : lcd_ctrl_pkg::LVL_VSS)
                    : (pol ? lcd_ctrl_pkg::LVL_VC : lcd_ctrl_pkg::LVL_VB);
        end
        for (gc = 0; gc < lcd_ctrl_pkg::NUM_SEG; gc++) begin : g_seg
            wire on = disp_mem[gc][slot_q] & com_mask[slot_q];
            assign seg_lvl_d[2*gc +: 2] =
                on ? (pol ? lcd_ctrl_pkg::LVL_VSS : lcd_ctrl_pkg::LVL_VA)
                   : (pol ? lcd_ctrl_pkg::LVL_VB : lcd_ctrl_pkg::LVL_VC);
        end
    endgenerate

    wire [3:0] bias_oh_d = 4'h1 << bias_src;

    // Output stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            com_lvl_q  <= 16'h0000;
            com_oe_q   <= 8'h00;
            com_rel_q  <= 8'h00;
            seg_lvl_q  <= 72'h0;
            seg_oe_q   <= 36'h0;
            pump_en_q  <= 1'b0;
            pump_clk_q <= 1'b0;
            bias_oh_q  <= 4'h1;
        end else begin
            com_rel_q  <= ~com_mask;
            bias_oh_q  <= bias_oh_d;
            pump_en_q  <= pump_run & ~float_req;
            pump_clk_q <= pump_run & ~float_req & pump_cnt_q[pump_tap];
            if (float_req) begin
                com_oe_q  <= 8'h00;
                seg_oe_q  <= 36'h0;
                com_lvl_q <= 16'h0000;
                seg_lvl_q <= 72'h0;
            end else if (disp_rst) begin
                com_oe_q  <= com_mask;
                seg_oe_q  <= {36{1'b1}};
                com_lvl_q <= 16'h0000;
                seg_lvl_q <= 72'h0;
            end else begin
                com_oe_q  <= com_mask;
                seg_oe_q  <= {36{1'b1}};
                com_lvl_q <= com_lvl_d;
                seg_lvl_q <= seg_lvl_d;
            end
        end
    end

    assign o_wb_ack          = ack_q;
    assign o_wb_dat          = rdat_q;
    assign o_com_lvl         = com_lvl_q;
    assign o_com_oe          = com_oe_q;
    assign o_com_release     = com_rel_q;
    assign o_seg_lvl         = seg_lvl_q;
    assign o_seg_oe          = seg_oe_q;
    assign o_pump_en         = pump_en_q;
    assign o_pump_clk        = pump_clk_q;
    assign o_bias_src_onehot = bias_oh_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_float_mcu_rst: assert property (
        i_mcu_rst |=> (o_com_oe == 8'h00) && (o_seg_oe == 36'h0))
        else $error("pins not floating during mcu reset");

    chk_blank_low: assert property (
        (!i_rst && !float_req && disp_rst) |=> (o_com_lvl == 16'h0000)
            && (o_seg_lvl == 72'h0) && (o_seg_oe == {36{1'b1}}))
        else $error("display reset does not drive pins low");

    chk_sleep_blank: assert property (
        (i_sleep && disp_en && !float_req) |=> (o_seg_lvl == 72'h0))
        else $error("sleep does not blank an enabled display");

    chk_wdt_excluded: assert property (
        (i_wdt_rst && (i_idle || i_sleep) && !i_mcu_rst)
            |=> (o_seg_oe != 36'h0))
        else $error("low power watchdog reset floated the pins");

    chk_ctl0_zero_bits: assert property (
        (wb_req && !ack_q && hit_ctl0) |=> (o_wb_dat[6:1] & 6'h27) == 6'h00)
        else $error("unimplemented control bits read nonzero");

    chk_mem_unused_com: assert property (
        (wb_req && !ack_q && hit_mem && duty == lcd_ctrl_pkg::DUTY_4COM)
            |=> o_wb_dat[7:4] == 4'h0)
        else $error("unused common bits read nonzero");

    chk_slot_range: assert property (
        slot_q <= slot_last || $changed(duty))
        else $error("slot beyond active commons");

    chk_com_release: assert property (
        $stable(duty) [*2] |-> (o_com_release & o_com_oe) == 8'h00)
        else $error("released common still driven");

    chk_typeb_pol_frame: assert property (
        (wave_type_b && lcd_tick && !disp_rst && slot_q != slot_last)
            |=> $stable(frame_pol_q))
        else $error("type b polarity flipped inside a frame");

    chk_pump_gate: assert property (
        (bias_src != lcd_ctrl_pkg::BIAS_EXT_PIN) |=> !o_pump_en && !o_pump_clk)
        else $error("pump running on internal bias source");

    chk_ctl2_zero_bits: assert property (
        (wb_req && !ack_q && hit_ctl2)
            |=> (o_wb_dat[4:3] == 2'h0) && !o_wb_dat[0])
        else $error("unimplemented pump and duty bits read nonzero");

    chk_wdt_run_float: assert property (
        (i_wdt_rst && !i_idle && !i_sleep)
            |=> (o_com_oe == 8'h00) && (o_seg_oe == 36'h0))
        else $error("active watchdog reset left the pins driven");

    chk_bias_top: assert property (
        (bias_src == lcd_ctrl_pkg::BIAS_INT_VDD)
            |=> (o_bias_src_onehot == 4'h8))
        else $error("core supply bias source not decoded");

    chk_seq_held: assert property (
        disp_rst |=> (slot_q == 3'h0) && !frame_pol_q && !half_q)
        else $error("sequencer ran while the display was in reset");

    chk_type_a_half: assert property (
        (!wave_type_b && lcd_tick && !disp_rst && slot_q <= slot_last)
            |=> (half_q != $past(half_q)))
        else $error("type a polarity did not flip on a tick");

    chk_ack_one_cycle: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("bus acknowledge stood longer than one cycle");

    chk_pump_fast_tap: assert property (
        (pump_run && !float_req && pump_div >= 3'h6)
            |=> (o_pump_clk == $past(pump_cnt_q[0])))
        else $error("pump divide by two not taken from counter bit 0");

    chk_pump_top_off: assert property (
        i_ext_top_bias_used |=> !o_pump_en)
        else $error("pump running with supply on the top pin");

    chk_release_six: assert property (
        (duty == lcd_ctrl_pkg::DUTY_6COM) |=> (o_com_release == 8'hC0))
        else $error("commons six and seven not released at six commons");

    chk_sleep_hold: assert property (
        (i_sleep && !float_req) |=> (o_com_lvl == 16'h0000))
        else $error("commons driven with waves during sleep");

    cov_type_a_frame: cover property (
        !wave_type_b && lcd_tick && half_q && slot_q == slot_last);
    cov_type_b_frame: cover property (
        wave_type_b && lcd_tick && slot_q == slot_last && !disp_rst);
    cov_sleep_entry: cover property (disp_en && $rose(i_sleep));
    cov_mcu_float: cover property ($rose(i_mcu_rst) && disp_en);
    cov_wdt_idle: cover property (i_wdt_rst && i_idle && disp_en);

endmodule : segment_lcd_driver_control

`default_nettype wire

// *** segment_lcd_driver_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_driver_control_bench;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
    logic        ack, sub_clk = 1'b0;
    logic        sleep = 1'b0, idle = 1'b0, mrst = 1'b0, wdt = 1'b0;
    logic        ext_top = 1'b0, pump_en, pump_clk, flt, blank;
    logic [15:0] com_lvl;
    logic [7:0]  com_oe, com_rel;
    logic [71:0] seg_lvl;
    logic [35:0] seg_oe;
    logic [3:0]  bias_oh;
    logic signed [3:0] pix;
    logic [31:0] rd;
    int          failures = 0, num_checks = 0, cycles = 0;
    int          n, a_cnt, b_cnt, sum;

    always #2.5 i_clk = ~i_clk;
    always #20 sub_clk = ~sub_clk;

    segment_lcd_driver_control dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'h1),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_sub_clk(sub_clk),
        .i_sleep(sleep), .i_idle(idle), .i_mcu_rst(mrst), .i_wdt_rst(wdt),
        .i_ext_top_bias_used(ext_top), .o_com_lvl(com_lvl),
        .o_com_oe(com_oe), .o_com_release(com_rel), .o_seg_lvl(seg_lvl),
        .o_seg_oe(seg_oe), .o_pump_en(pump_en), .o_pump_clk(pump_clk),
        .o_bias_src_onehot(bias_oh));

    lcd_panel_model panel_u (
        .i_clk(i_clk), .i_com_lvl(com_lvl), .i_com_oe(com_oe),
        .i_seg_lvl(seg_lvl), .i_seg_oe(seg_oe), .o_float(flt),
        .o_blank(blank), .o_pix_diff(pix));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
            failures++;
        end
    endtask : check

    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [7:0] d, output logic [31:0] r);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge i_clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : wb

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [31:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 8'h00, r);
        check(nm, exp, r);
    endtask : rd_chk

    // Counts clocks up to the next sampled rising edge of the pump clock
    task automatic wait_rise(output int k);
        logic p;
        k = 0;
        do begin
            p = pump_clk;
            @(posedge i_clk);
            k++;
        end while (!(pump_clk === 1'b1 && p === 1'b0) && k < 5000);
    endtask : wait_rise

    task automatic com0_changes(output int k);
        logic [1:0] p;
        k = 0;
        repeat (1024) begin
            p = com_lvl[1:0];
            @(posedge i_clk);
            if (com_lvl[1:0] !== p) k++;
        end
    endtask : com0_changes

    // One waveform period is 8 ticks of 64 clocks from any com0 change
    task automatic dc_sum();
        logic [1:0] p;
        p = com_lvl[1:0];
        while (com_lvl[1:0] === p) @(posedge i_clk);
        sum = 0;
        repeat (512) begin
            sum += pix;
            @(posedge i_clk);
        end
        check("dc_sum", 32'h0, sum);
    endtask : dc_sum

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("com_oe_rst", 32'h0F, com_oe);
        check("release_rst", 32'hF0, com_rel);
        check("blank_rst", 32'h1, blank);
        rd_chk("ctl0_rst", 32'h0, 32'h0);
        rd_chk("ctl2_rst", 32'h4, 32'h0);
        wr(32'h0, 8'hFF);
        rd_chk("ctl0_mask", 32'h0, 32'hB1);
        wr(32'h4, 8'hFF);
        rd_chk("ctl2_mask", 32'h4, 32'hE6);
        rd_chk("unmapped", 32'h80, 32'h0);
        for (int b = 0; b < 4; b++) begin
            wr(32'h0, {2'h0, b[1:0], 4'h0});
            check("bias_oh", 32'h1 << b, bias_oh);
            check("pump_en", (b == 0), pump_en);
        end
        wr(32'h0, 8'h00);
        ext_top <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("pump_top", 32'h0, pump_en);
        ext_top <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            wr(32'h4, {5'h0, d[1:0], 1'b0});
            n = (d == 0) ? 32'h0F : (d == 1) ? 32'h3F : 32'hFF;
            check("release", ~n & 32'hFF, com_rel);
            check("com_oe", n, com_oe);
        end
        wr(32'h0, 8'h01);
        repeat (300) @(posedge i_clk);
        check("blank_d11", 32'h1, blank);
        wr(32'h4, 8'h00);
        // Display memory powers up unknown
        for (int i = 0; i < 36; i++)
            wr(32'h100 + 4 * i, 8'h00);
        wr(32'h100, 8'hFF);
        rd_chk("mem_1_4", 32'h100, 32'h0F);
        wr(32'h100, 8'h00);
        repeat (600) @(posedge i_clk);
        check("normal", 32'h0, blank);
        repeat (8) begin
            n = 0;
            for (int c = 0; c < 4; c++)
                if (com_lvl[2*c+:2] == 2'h3 || com_lvl[2*c+:2] == 2'h0) n++;
            check("one_sel", 32'h1, n);
            repeat (64) @(posedge i_clk);
        end
        com0_changes(a_cnt);
        dc_sum();
        wr(32'h0, 8'h81);
        repeat (600) @(posedge i_clk);
        com0_changes(b_cnt);
        check("a_faster", 32'h1, a_cnt > b_cnt);
        dc_sum();
        sleep <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("sleep_blank", 32'h1, blank);
        check("sleep_oe", 32'h0F, com_oe);
        sleep <= 1'b0;
        wr(32'h0, 8'h80);
        check("dis_blank", 32'h1, blank);
        wr(32'h0, 8'h01);
        mrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("mcu_float", 32'h1, flt);
        mrst <= 1'b0;
        idle <= 1'b1;
        wdt <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("wdt_idle", 32'h0F, com_oe);
        idle <= 1'b0;
        repeat (4) @(posedge i_clk);
        check("wdt_run", 32'h1, flt);
        wdt <= 1'b0;
        wr(32'h0, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wr(32'h4, {c[2:0], 5'h0});
            wait_rise(n);
            wait_rise(n);
            check("pump_per", (c < 6) ? (1024 >> c) : 16, n);
        end
        stop_test();
    end
endmodule : segment_lcd_driver_control_bench
`default_nettype wire
